// ### verilog/plut_port.sv
// palette look-up table host access port
`include "plut_defs.svh"

module plut_port (
	input  wire logic                       i_mclk,
	input  wire logic                       i_sys_rst,
	input  wire logic [`PLUT_IO_ADDR_W-1:0] i_io_addr,
	input  wire logic                       i_io_wr,
	input  wire logic                       i_io_rd,
	input  wire logic [`PLUT_DATA_W-1:0]    i_io_wdata,
	output logic                            o_io_ready,
	output logic                            o_io_rvalid,
	input  wire logic                       i_io_rready,
	output logic [`PLUT_DATA_W-1:0]         o_io_rdata
);

	plut_pkg::plut_state_s   st;
	plut_pkg::plut_state_s   next_st;
	logic [`PLUT_ENTRY_W-1:0] lut [2**`PLUT_PTR_W];
	logic [`PLUT_ENTRY_W-1:0] rd_entry;
	logic                     lut_we;
	logic                     push_valid;
	logic [`PLUT_DATA_W-1:0]  push_data;
	logic                     buf_ready;
	logic                     wr_rp;
	logic                     wr_wp;
	logic                     wr_dat;
	logic                     rd_stat;
	logic                     rd_dat;

	////////////////////////////////////////////////////////////////
	// component sequence step shared by reads and writes
	function automatic plut_pkg::plut_comp_e comp_step(input plut_pkg::plut_comp_e c);
		unique case (c)
			plut_pkg::PLUT_RED: begin
				comp_step = plut_pkg::PLUT_GREEN;
			end
			plut_pkg::PLUT_GREEN: begin
				comp_step = plut_pkg::PLUT_BLUE;
			end
			plut_pkg::PLUT_BLUE: begin
				comp_step = plut_pkg::PLUT_RED;
			end
			default: begin
				comp_step = plut_pkg::PLUT_RED;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// port decode, writes always taken, reads wait for buffer room
	assign wr_rp   = i_io_wr && (i_io_addr == `PLUT_PORT_RD_PTR);
	assign wr_wp   = i_io_wr && (i_io_addr == `PLUT_PORT_WR_PTR);
	assign wr_dat  = i_io_wr && (i_io_addr == `PLUT_PORT_DATA);
	assign rd_stat = i_io_rd && !i_io_wr && buf_ready && (i_io_addr == `PLUT_PORT_STATUS);
	assign rd_dat  = i_io_rd && !i_io_wr && buf_ready && (i_io_addr == `PLUT_PORT_DATA);

	assign rd_entry = lut[st.rd_ptr];

	////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		lut_we = 1'b0;
		push_valid = 1'b0;
		push_data = '0;
		if (wr_rp) begin
			next_st.rd_ptr = i_io_wdata;
			next_st.comp = plut_pkg::PLUT_RED;
			next_st.dir_read = 1'b1;
		end else if (wr_wp) begin
			next_st.wr_ptr = i_io_wdata;
			next_st.comp = plut_pkg::PLUT_RED;
			next_st.dir_read = 1'b0;
		end else if (wr_dat) begin
			next_st.comp = comp_step(st.comp);
			unique case (st.comp)
				plut_pkg::PLUT_RED: begin
					next_st.hold_r = i_io_wdata;
				end
				plut_pkg::PLUT_GREEN: begin
					next_st.hold_g = i_io_wdata;
				end
				plut_pkg::PLUT_BLUE: begin
					lut_we = 1'b1;
					next_st.wr_ptr = st.wr_ptr + `PLUT_PTR_STEP;
				end
				default: begin
					next_st.comp = plut_pkg::PLUT_RED;
				end
			endcase
		end else if (rd_stat) begin
			push_valid = 1'b1;
			push_data = {`PLUT_STAT_RSVD, st.dir_read ? `PLUT_STAT_READING : `PLUT_STAT_WRITING};
		end else if (rd_dat) begin
			push_valid = 1'b1;
			next_st.comp = comp_step(st.comp);
			unique case (st.comp)
				plut_pkg::PLUT_RED: begin
					push_data = rd_entry[`PLUT_RED_MSB:`PLUT_RED_LSB];
				end
				plut_pkg::PLUT_GREEN: begin
					push_data = rd_entry[`PLUT_GREEN_MSB:`PLUT_GREEN_LSB];
				end
				plut_pkg::PLUT_BLUE: begin
					push_data = rd_entry[`PLUT_BLUE_MSB:`PLUT_BLUE_LSB];
					next_st.rd_ptr = st.rd_ptr + `PLUT_PTR_STEP;
				end
				default: begin
					push_valid = 1'b0;
					next_st.comp = plut_pkg::PLUT_RED;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st.rd_ptr <= `PLUT_RST_PTR;
			st.wr_ptr <= `PLUT_RST_PTR;
			st.comp <= plut_pkg::PLUT_RED;
			st.hold_r <= `PLUT_RST_HOLD;
			st.hold_g <= `PLUT_RST_HOLD;
			st.dir_read <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// table storage, whole entry written at once
	always_ff @(posedge i_mclk) begin
		if (lut_we) begin
			lut[st.wr_ptr] <= {st.hold_r, st.hold_g, i_io_wdata};
		end
	end

	////////////////////////////////////////////////////////////////
	// read answers queue here so a stalled host loses none
	plut_skid #(
		.W (`PLUT_DATA_W)
	) u_rbuf (
		.i_mclk      (i_mclk),
		.i_sys_rst   (i_sys_rst),
		.i_in_valid  (push_valid),
		.o_in_ready  (buf_ready),
		.i_in_data   (push_data),
		.o_out_valid (o_io_rvalid),
		.i_out_ready (i_io_rready),
		.o_out_data  (o_io_rdata)
	);

	assign o_io_ready = buf_ready;

	////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	sequence s_rd_blue;
		rd_dat && st.comp == plut_pkg::PLUT_BLUE;
	endsequence

	sequence s_wr_blue;
		wr_dat && !wr_rp && !wr_wp && st.comp == plut_pkg::PLUT_BLUE;
	endsequence

	sequence s_wr_red_green;
		wr_dat && st.comp == plut_pkg::PLUT_RED ##1 wr_dat[*1];
	endsequence

	sequence s_rp_then_stat;
		wr_rp ##1 rd_stat;
	endsequence

	sequence s_wp_then_stat;
		wr_wp ##1 rd_stat;
	endsequence

	a_rd_ptr_load: assert property (wr_rp |=> st.rd_ptr == $past(i_io_wdata) && st.comp == plut_pkg::PLUT_RED)
		else $error("read pointer not loaded");

	a_rd_ptr_adv: assert property (s_rd_blue |=> st.rd_ptr == $past(st.rd_ptr) + `PLUT_PTR_STEP)
		else $error("read pointer did not advance");

	a_rd_ptr_hold: assert property (rd_dat && st.comp != plut_pkg::PLUT_BLUE |=> $stable(st.rd_ptr))
		else $error("read pointer moved early");

	a_wr_ptr_load: assert property (wr_wp |=> st.wr_ptr == $past(i_io_wdata) && st.comp == plut_pkg::PLUT_RED)
		else $error("write pointer not loaded");

	a_wr_ptr_adv: assert property (s_wr_blue |=> st.wr_ptr == $past(st.wr_ptr) + `PLUT_PTR_STEP)
		else $error("write pointer did not advance");

	a_dir_status: assert property (s_rp_then_stat |-> push_data == 8'h03)
		else $error("status not reading after read pointer");

	a_dir_write: assert property (s_wp_then_stat |-> push_data == {`PLUT_STAT_RSVD, `PLUT_STAT_WRITING})
		else $error("status not writing after write pointer");

	a_wr_ptr_hold: assert property (wr_dat && st.comp != plut_pkg::PLUT_BLUE |=> $stable(st.wr_ptr))
		else $error("write pointer moved early");

	a_rd_comp_step: assert property (rd_dat && st.comp == plut_pkg::PLUT_RED |=> st.comp == plut_pkg::PLUT_GREEN)
		else $error("green does not follow red read");

	a_stat_bits: assert property (rd_stat |-> push_data[7:2] == `PLUT_STAT_RSVD && push_data[1] == push_data[0])
		else $error("status bits disagree");

	a_hold_colour: assert property (s_wr_red_green |-> st.hold_r == $past(i_io_wdata) && !lut_we)
		else $error("red not held before commit");

	a_commit_entry: assert property (s_wr_blue |=> lut[$past(st.wr_ptr)] == {$past(st.hold_r), $past(st.hold_g), $past(i_io_wdata)})
		else $error("entry not committed on third write");

	a_red_first: assert property (wr_rp ##1 rd_dat |-> push_data == rd_entry[`PLUT_RED_MSB:`PLUT_RED_LSB])
		else $error("first read is not red");

endmodule

// ### verilog/plut_defs.svh
// constants for the palette look-up table access port
`ifndef PLUT_DEFS_SVH
`define PLUT_DEFS_SVH

`define PLUT_IO_ADDR_W      16
`define PLUT_DATA_W         8
`define PLUT_PTR_W          8
`define PLUT_ENTRY_W        24

`define PLUT_PORT_RD_PTR    16'h03c7
`define PLUT_PORT_STATUS    16'h03c7
`define PLUT_PORT_WR_PTR    16'h03c8
`define PLUT_PORT_DATA      16'h03c9

`define PLUT_RED_MSB        23
`define PLUT_RED_LSB        16
`define PLUT_GREEN_MSB      15
`define PLUT_GREEN_LSB      8
`define PLUT_BLUE_MSB       7
`define PLUT_BLUE_LSB       0

`define PLUT_STAT_WRITING   2'h0
`define PLUT_STAT_READING   2'h3
`define PLUT_STAT_RSVD      6'h00

`define PLUT_RST_PTR        8'h00
`define PLUT_RST_HOLD       8'h00
`define PLUT_PTR_STEP       8'h01

`endif

// ### verilog/plut_pkg.sv
// types for the palette look-up table access port
`include "plut_defs.svh"

package plut_pkg;

	typedef enum logic [1:0] {
		PLUT_RED   = 2'b00,
		PLUT_GREEN = 2'b01,
		PLUT_BLUE  = 2'b10
	} plut_comp_e;

	typedef struct packed {
		logic [`PLUT_PTR_W-1:0]  rd_ptr;
		logic [`PLUT_PTR_W-1:0]  wr_ptr;
		plut_comp_e              comp;
		logic [`PLUT_DATA_W-1:0] hold_r;
		logic [`PLUT_DATA_W-1:0] hold_g;
		logic                    dir_read;
	} plut_state_s;

endpackage

// ### verilog/plut_skid.sv
// two-entry buffer with valid and ready on both sides
module plut_skid #(
	parameter int W = 8
)(
	input  wire logic         i_mclk,
	input  wire logic         i_sys_rst,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);

	typedef struct packed {
		logic [W-1:0] head;
		logic         head_v;
		logic [W-1:0] skid;
		logic         skid_v;
		logic         room;
	} plut_skid_s;

	plut_skid_s st;
	plut_skid_s next_st;
	logic       take;

	////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		take = i_in_valid & ~st.skid_v;
		if (i_out_ready || !st.head_v) begin
			if (st.skid_v) begin
				next_st.head = st.skid;
				next_st.head_v = 1'b1;
				next_st.skid_v = 1'b0;
			end else begin
				next_st.head = take ? i_in_data : st.head;
				next_st.head_v = take;
			end
			if (st.skid_v && take) begin
				next_st.skid = i_in_data;
				next_st.skid_v = 1'b1;
			end
		end else if (take) begin
			next_st.skid = i_in_data;
			next_st.skid_v = 1'b1;
		end
		next_st.room = ~next_st.skid_v;
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			st <= plut_skid_s'{head: '0, head_v: 1'b0, skid: '0, skid_v: 1'b0, room: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign o_in_ready  = st.room;
	assign o_out_valid = st.head_v;
	assign o_out_data  = st.head;

	////////////////////////////////////////////////////////////////
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	a_buf_no_loss: assert property (st.head_v && !i_out_ready |=> st.head_v && $stable(st.head))
		else $error("buffer head changed while stalled");
	a_buf_fill_stall: assert property (st.head_v && !i_out_ready && i_in_valid && !st.skid_v |=> !o_in_ready)
		else $error("buffer did not fill under stall");

endmodule

// ### tb/plut_host_model.sv
// host model issuing io reads and writes to the lut access port
`include "plut_defs.svh"
module plut_host_model (
	input  wire logic                       i_mclk,
	input  wire logic                       i_io_ready,
	input  wire logic                       i_io_rvalid,
	input  wire logic [`PLUT_DATA_W-1:0]    i_io_rdata,
	output logic      [`PLUT_IO_ADDR_W-1:0] o_io_addr,
	output logic                            o_io_wr,
	output logic                            o_io_rd,
	output logic      [`PLUT_DATA_W-1:0]    o_io_wdata,
	output logic                            o_io_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_io_addr = 16'h0000;
		o_io_wr = 1'b0;
		o_io_rd = 1'b0;
		o_io_wdata = 8'h00;
		o_io_rready = 1'b0;
	end
	// one write strobe; caller sets pointer first, then red green blue
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_io_addr <= a;
		o_io_wr <= 1'b1;
		o_io_wdata <= d;
		@(posedge i_mclk);
		o_io_wr <= 1'b0;
		o_io_wdata <= ~d;
	endtask
	// two writes on consecutive edges, strobe held high between them
	task automatic wr2(input logic [15:0] a0, input logic [7:0] d0, input logic [15:0] a1, input logic [7:0] d1);
		@(posedge i_mclk);
		o_io_addr <= a0;
		o_io_wr <= 1'b1;
		o_io_wdata <= d0;
		@(posedge i_mclk);
		o_io_addr <= a1;
		o_io_wdata <= d1;
		@(posedge i_mclk);
		o_io_wr <= 1'b0;
		o_io_wdata <= ~d1;
	endtask
	// pointer write, then a read request on the very next edge
	task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, input logic [15:0] ra);
		logic r;
		@(posedge i_mclk);
		o_io_addr <= a;
		o_io_wr <= 1'b1;
		o_io_wdata <= d;
		@(posedge i_mclk);
		o_io_wr <= 1'b0;
		o_io_wdata <= ~d;
		o_io_addr <= ra;
		o_io_rd <= 1'b1;
		do begin
			@(negedge i_mclk);
			r = i_io_ready;
			@(posedge i_mclk);
		end while (r !== 1'b1);
		o_io_rd <= 1'b0;
	endtask
	// read held until an edge with ready high
	task automatic issue_rd(input logic [15:0] a);
		logic r;
		@(posedge i_mclk);
		o_io_addr <= a;
		o_io_rd <= 1'b1;
		do begin
			@(negedge i_mclk);
			r = i_io_ready;
			@(posedge i_mclk);
		end while (r !== 1'b1);
		o_io_rd <= 1'b0;
	endtask
	// accept one answer after a stall
	task automatic take_ans(input int stall, output logic [7:0] d);
		logic r;
		repeat (stall) @(posedge i_mclk);
		@(posedge i_mclk);
		o_io_rready <= 1'b1;
		do begin
			@(negedge i_mclk);
			d = i_io_rdata;
			r = i_io_rvalid;
			@(posedge i_mclk);
		end while (r !== 1'b1);
		o_io_rready <= 1'b0;
	endtask
endmodule

// ### tb/test_palette_lut_access_port.sv
// self-checking bench for the palette lut access port
`include "plut_defs.svh"
module test_palette_lut_access_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk;
	logic        sys_rst;
	logic [15:0] io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic        io_ready;
	logic        io_rvalid;
	logic        io_rready;
	logic [7:0]  io_rdata;
	int          errors;
	int          tests_run;
	int          lut [256];
	int          rp, wp, comp, hr, hg;
	logic [1:0]  st;
	logic [7:0]  p;
	plut_port dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_io_addr(io_addr), .i_io_wr(io_wr),
		.i_io_rd(io_rd), .i_io_wdata(io_wdata), .o_io_ready(io_ready), .o_io_rvalid(io_rvalid),
		.i_io_rready(io_rready), .o_io_rdata(io_rdata));
	plut_host_model host (.i_mclk(mclk), .i_io_ready(io_ready), .i_io_rvalid(io_rvalid),
		.i_io_rdata(io_rdata), .o_io_addr(io_addr), .o_io_wr(io_wr), .o_io_rd(io_rd),
		.o_io_wdata(io_wdata), .o_io_rready(io_rready));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#500000;
		errors++;
		close_out();
	end
	task automatic close_out();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// write through the host and update the reference
	task automatic mwr(input logic [15:0] a, input logic [7:0] d);
		host.wr(a, d);
		upd(a, d);
	endtask
	task automatic upd(input logic [15:0] a, input logic [7:0] d);
		if (a == `PLUT_PORT_RD_PTR) begin
			rp = d;
			comp = 0;
			st = 2'h3;
		end else if (a == `PLUT_PORT_WR_PTR) begin
			wp = d;
			comp = 0;
			st = 2'h0;
		end else if (a == `PLUT_PORT_DATA) begin
			if (comp == 0) hr = d;
			else if (comp == 1) hg = d;
			else begin
				lut[wp] = (hr << 16) | (hg << 8) | d;
				wp = (wp + 1) % 256;
			end
			comp = (comp + 1) % 3;
		end
	endtask
	// take one answer and compare with the reference
	task automatic mans(input logic [15:0] a, input int stall);
		logic [7:0] d, e;
		host.take_ans(stall, d);
		if (a == `PLUT_PORT_STATUS) e = {6'h00, st};
		else begin
			e = 8'(lut[rp] >> (8 * (2 - comp)));
			comp = (comp + 1) % 3;
			if (comp == 0) rp = (rp + 1) % 256;
		end
		chk(d, e);
	endtask
	task automatic mrd(input logic [15:0] a, input int stall);
		host.issue_rd(a);
		mans(a, stall);
	endtask
	initial begin
		errors = 0;
		tests_run = 0;
		{rp, wp, comp, hr, hg} = '0;
		st = 2'h0;
		sys_rst = 1'b1;
		void'($urandom(90));
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		mrd(`PLUT_PORT_STATUS, 0);
		for (int k = 0; k < 4; k++) begin
			p = (k == 0) ? 8'hff : 8'($urandom);
			mwr(`PLUT_PORT_WR_PTR, p);
			for (int i = 0; i < 6; i++) mwr(`PLUT_PORT_DATA, 8'($urandom));
			mrd(`PLUT_PORT_STATUS, 0);
			mwr(`PLUT_PORT_RD_PTR, p);
			mrd(`PLUT_PORT_STATUS, 1);
			for (int i = 0; i < 6; i++) mrd(`PLUT_PORT_DATA, $urandom_range(3));
		end
		p = 8'($urandom);
		host.wr_rd(`PLUT_PORT_WR_PTR, p, `PLUT_PORT_STATUS);
		upd(`PLUT_PORT_WR_PTR, p);
		mans(`PLUT_PORT_STATUS, 0);
		host.wr2(`PLUT_PORT_DATA, 8'h3c, `PLUT_PORT_DATA, 8'hc3);
		upd(`PLUT_PORT_DATA, 8'h3c);
		upd(`PLUT_PORT_DATA, 8'hc3);
		mwr(`PLUT_PORT_DATA, 8'h69);
		host.wr_rd(`PLUT_PORT_RD_PTR, p, `PLUT_PORT_STATUS);
		upd(`PLUT_PORT_RD_PTR, p);
		mans(`PLUT_PORT_STATUS, 0);
		host.wr_rd(`PLUT_PORT_RD_PTR, p, `PLUT_PORT_DATA);
		upd(`PLUT_PORT_RD_PTR, p);
		mans(`PLUT_PORT_DATA, 0);
		mwr(`PLUT_PORT_WR_PTR, 8'hff);
		mwr(`PLUT_PORT_DATA, 8'h5a);
		mwr(`PLUT_PORT_DATA, 8'ha5);
		mwr(`PLUT_PORT_RD_PTR, 8'hff);
		for (int i = 0; i < 3; i++) mrd(`PLUT_PORT_DATA, 0);
		mwr(`PLUT_PORT_WR_PTR, 8'h00);
		for (int i = 0; i < 3; i++) mwr(`PLUT_PORT_DATA, 8'($urandom));
		mwr(`PLUT_PORT_RD_PTR, 8'h00);
		mrd(`PLUT_PORT_DATA, 0);
		mwr(`PLUT_PORT_RD_PTR, 8'h00);
		host.issue_rd(`PLUT_PORT_DATA);
		host.issue_rd(`PLUT_PORT_DATA);
		repeat (3) @(negedge mclk);
		chk({7'h00, io_ready}, 8'h00);
		mans(`PLUT_PORT_DATA, 2);
		mans(`PLUT_PORT_DATA, 0);
		mrd(`PLUT_PORT_DATA, 0);
		host.issue_rd(`PLUT_PORT_WR_PTR);
		host.issue_rd(16'h1234);
		repeat (4) @(negedge mclk);
		chk({7'h00, io_rvalid}, 8'h00);
		close_out();
	end
endmodule
